// ===== verilog/sofc_top.sv
// serial output format configuration: serial port registers, staging and active
// copies, output data clock tap select, and the formatted output word
// assumes serial port pins are synchronous to i_clk and slow against it
`timescale 1ns/1ns

// How it works
// [R01] each phase code step shifts clock 60 degrees
// [R02] codes 1011 to 1111 all give 660 degrees
// [R03] phase register resets to 0x03, 180 degrees
// [R04] phase picks divider tap only, capture unchanged
// [R05] format bits select offset/twos, bit2 inverts
// [R06] pattern one: low byte 19, high 1A
// [R07] pattern two low byte at 1B, reset zero
// [R08] pattern two high byte at 1C
// [R09] test mode 1000 outputs user patterns
// [R10] writes act only after software transfer bit
// [R11] inversion after format, clocks unaffected
module sofc_top (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_sclk,
    input  wire logic                        i_csb,
    input  wire logic                        i_sdio,
    output logic                             o_sdio,
    output logic                             o_sdio_oe,
    input  sofc_pkg::sofc_sample_t           i_sample,
    output logic                             o_output_data_clock,
    output logic                             o_frame_strobe,
    output logic [sofc_pkg::SAMPLE_W-1:0]    o_word,
    output logic                             o_word_valid,
    output logic [1:0]                       o_drive_term,
    output logic                             o_low_power
);
    logic                      rst_q1_reg;
    logic                      rst_q2_reg;
    logic                      rst_n;

    logic                      sclk_reg;
    logic                      sclk_rise;
    logic                      sclk_fall;

    sofc_pkg::sofc_spi_state_t state_reg;
    logic [15:0]               shift_reg;
    logic [4:0]                instr_cnt_reg;
    logic [2:0]                data_cnt_reg;
    logic                      read_reg;
    logic [12:0]               addr_reg;
    logic [7:0]                rd_shift_reg;
    logic [15:0]               instr_word;
    logic [7:0]                wr_byte;
    logic                      wr_pulse;
    logic                      xfer_pulse;
    logic                      soft_reset;

    logic [7:0]                stg_modes_reg;
    logic [7:0]                stg_test_reg;
    logic [7:0]                stg_format_reg;
    logic [7:0]                stg_drive_reg;
    logic [7:0]                stg_phase_reg;
    logic [7:0]                stg_p1l_reg;
    logic [7:0]                stg_p1h_reg;
    logic [7:0]                stg_p2l_reg;
    logic [7:0]                stg_p2h_reg;

    logic [7:0]                act_modes_reg;
    logic [7:0]                act_test_reg;
    logic [7:0]                act_format_reg;
    logic [7:0]                act_drive_reg;
    logic [7:0]                act_phase_reg;
    logic [7:0]                act_p1l_reg;
    logic [7:0]                act_p1h_reg;
    logic [7:0]                act_p2l_reg;
    logic [7:0]                act_p2h_reg;

    logic [2:0]                step_reg;
    logic [3:0]                phase_eff;
    logic [3:0]                tap_shift;
    logic [3:0]                tap_idx;
    logic                      dclk_next;
    sofc_pkg::sofc_cfg_t       cfg;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_q1_reg <= 1'b0;
            rst_q2_reg <= 1'b0;
        end else begin
            rst_q1_reg <= 1'b1;
            rst_q2_reg <= rst_q1_reg;
        end
    end
    assign rst_n = rst_q2_reg;

    // serial clock is sampled, so it must stay well below i_clk
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_reg <= 1'b0;
        end else begin
            sclk_reg <= i_sclk;
        end
    end
    assign sclk_rise = i_sclk && !sclk_reg && !i_csb;
    assign sclk_fall = !i_sclk && sclk_reg && !i_csb;

    assign instr_word = {shift_reg[14:0], i_sdio};
    assign wr_byte    = {shift_reg[6:0], i_sdio};

    function automatic logic [7:0] reg_read(input logic [12:0] a);
        logic [7:0] d;
        d = sofc_pkg::READ_NONE;
        if (a == sofc_pkg::ADDR_MODES) begin
            d = stg_modes_reg;
        end else if (a == sofc_pkg::ADDR_TEST_IO) begin
            d = stg_test_reg;
        end else if (a == sofc_pkg::ADDR_FORMAT) begin
            d = stg_format_reg;
        end else if (a == sofc_pkg::ADDR_DRIVE) begin
            d = stg_drive_reg;
        end else if (a == sofc_pkg::ADDR_PHASE) begin
            d = stg_phase_reg;
        end else if (a == sofc_pkg::ADDR_PAT1_LO) begin
            d = stg_p1l_reg;
        end else if (a == sofc_pkg::ADDR_PAT1_HI) begin
            d = stg_p1h_reg;
        end else if (a == sofc_pkg::ADDR_PAT2_LO) begin
            d = stg_p2l_reg;
        end else if (a == sofc_pkg::ADDR_PAT2_HI) begin
            d = stg_p2h_reg;
        end
        return d;
    endfunction : reg_read

    // serial port: 16-bit instruction, then bytes to descending addresses
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= sofc_pkg::SOFC_SPI_IDLE;
            shift_reg     <= '0;
            instr_cnt_reg <= '0;
            data_cnt_reg  <= '0;
            read_reg      <= 1'b0;
            addr_reg      <= '0;
            rd_shift_reg  <= '0;
        end else if (i_csb) begin
            state_reg     <= sofc_pkg::SOFC_SPI_IDLE;
            instr_cnt_reg <= '0;
            data_cnt_reg  <= '0;
        end else begin
            case (state_reg)
                sofc_pkg::SOFC_SPI_IDLE: begin
                    state_reg <= sofc_pkg::SOFC_SPI_INSTR;
                end
                sofc_pkg::SOFC_SPI_INSTR: begin
                    if (sclk_rise) begin
                        shift_reg     <= instr_word;
                        instr_cnt_reg <= instr_cnt_reg + 5'h01;
                        if (instr_cnt_reg == sofc_pkg::INSTR_LAST) begin
                            read_reg     <= instr_word[sofc_pkg::READ_BIT];
                            addr_reg     <= instr_word[sofc_pkg::ADDR_W-1:0];
                            rd_shift_reg <= reg_read(instr_word[sofc_pkg::ADDR_W-1:0]);
                            data_cnt_reg <= '0;
                            state_reg    <= sofc_pkg::SOFC_SPI_DATA;
                        end
                    end
                end
                sofc_pkg::SOFC_SPI_DATA: begin
                    if (sclk_rise) begin
                        shift_reg    <= {8'h00, wr_byte};
                        data_cnt_reg <= data_cnt_reg + 3'h1;
                        if (data_cnt_reg == sofc_pkg::DATA_LAST) begin
                            addr_reg     <= addr_reg - 13'h0001;
                            rd_shift_reg <= reg_read(addr_reg - 13'h0001);
                        end
                    end else if (sclk_fall && data_cnt_reg != 3'h0) begin
                        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
                    end
                end
                default: begin
                    state_reg <= sofc_pkg::SOFC_SPI_IDLE;
                end
            endcase
        end
    end

    assign wr_pulse = state_reg == sofc_pkg::SOFC_SPI_DATA && sclk_rise && !read_reg
                      && data_cnt_reg == sofc_pkg::DATA_LAST;
    assign xfer_pulse = wr_pulse && addr_reg == sofc_pkg::ADDR_UPDATE
                        && wr_byte[sofc_pkg::XFER_BIT]; // [R10]
    assign soft_reset = act_modes_reg[sofc_pkg::MODES_HI:0] == sofc_pkg::MODES_RESET;

    assign o_sdio    = rd_shift_reg[7];
    assign o_sdio_oe = state_reg == sofc_pkg::SOFC_SPI_DATA && read_reg && !i_csb;

    // staging copy: what the host writes and reads back
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            stg_modes_reg  <= sofc_pkg::RST_MODES;
            stg_test_reg   <= sofc_pkg::RST_TEST_IO;
            stg_format_reg <= sofc_pkg::RST_FORMAT; // [R05]
            stg_drive_reg  <= sofc_pkg::RST_DRIVE;
            stg_phase_reg  <= sofc_pkg::RST_PHASE; // [R03]
            stg_p1l_reg    <= sofc_pkg::RST_PAT; // [R06]
            stg_p1h_reg    <= sofc_pkg::RST_PAT; // [R06]
            stg_p2l_reg    <= sofc_pkg::RST_PAT; // [R07]
            stg_p2h_reg    <= sofc_pkg::RST_PAT; // [R08]
        end else if (soft_reset) begin
            stg_modes_reg  <= sofc_pkg::RST_MODES;
            stg_test_reg   <= sofc_pkg::RST_TEST_IO;
            stg_format_reg <= sofc_pkg::RST_FORMAT;
            stg_drive_reg  <= sofc_pkg::RST_DRIVE;
            stg_phase_reg  <= sofc_pkg::RST_PHASE; // [R03]
            stg_p1l_reg    <= sofc_pkg::RST_PAT;
            stg_p1h_reg    <= sofc_pkg::RST_PAT;
            stg_p2l_reg    <= sofc_pkg::RST_PAT;
            stg_p2h_reg    <= sofc_pkg::RST_PAT;
        end else if (wr_pulse) begin
            if (addr_reg == sofc_pkg::ADDR_MODES) begin
                stg_modes_reg <= wr_byte;
            end else if (addr_reg == sofc_pkg::ADDR_TEST_IO) begin
                stg_test_reg <= wr_byte;
            end else if (addr_reg == sofc_pkg::ADDR_FORMAT) begin
                stg_format_reg <= wr_byte;
            end else if (addr_reg == sofc_pkg::ADDR_DRIVE) begin
                stg_drive_reg <= wr_byte;
            end else if (addr_reg == sofc_pkg::ADDR_PHASE) begin
                stg_phase_reg <= wr_byte;
            end else if (addr_reg == sofc_pkg::ADDR_PAT1_LO) begin
                stg_p1l_reg <= wr_byte; // [R06]
            end else if (addr_reg == sofc_pkg::ADDR_PAT1_HI) begin
                stg_p1h_reg <= wr_byte; // [R06]
            end else if (addr_reg == sofc_pkg::ADDR_PAT2_LO) begin
                stg_p2l_reg <= wr_byte; // [R07]
            end else if (addr_reg == sofc_pkg::ADDR_PAT2_HI) begin
                stg_p2h_reg <= wr_byte; // [R08]
            end
        end
    end

    // active copy: only the transfer moves staging values into use
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_modes_reg  <= sofc_pkg::RST_MODES;
            act_test_reg   <= sofc_pkg::RST_TEST_IO;
            act_format_reg <= sofc_pkg::RST_FORMAT;
            act_drive_reg  <= sofc_pkg::RST_DRIVE;
            act_phase_reg  <= sofc_pkg::RST_PHASE; // [R03]
            act_p1l_reg    <= sofc_pkg::RST_PAT;
            act_p1h_reg    <= sofc_pkg::RST_PAT;
            act_p2l_reg    <= sofc_pkg::RST_PAT;
            act_p2h_reg    <= sofc_pkg::RST_PAT;
        end else if (soft_reset) begin
            act_modes_reg  <= sofc_pkg::RST_MODES;
            act_test_reg   <= sofc_pkg::RST_TEST_IO;
            act_format_reg <= sofc_pkg::RST_FORMAT;
            act_drive_reg  <= sofc_pkg::RST_DRIVE;
            act_phase_reg  <= sofc_pkg::RST_PHASE;
            act_p1l_reg    <= sofc_pkg::RST_PAT;
            act_p1h_reg    <= sofc_pkg::RST_PAT;
            act_p2l_reg    <= sofc_pkg::RST_PAT;
            act_p2h_reg    <= sofc_pkg::RST_PAT;
        end else if (xfer_pulse) begin // [R10]
            act_modes_reg  <= stg_modes_reg;
            act_test_reg   <= stg_test_reg;
            act_format_reg <= stg_format_reg;
            act_drive_reg  <= stg_drive_reg;
            act_phase_reg  <= stg_phase_reg;
            act_p1l_reg    <= stg_p1l_reg;
            act_p1h_reg    <= stg_p1h_reg;
            act_p2l_reg    <= stg_p2l_reg;
            act_p2h_reg    <= stg_p2h_reg;
        end
    end

    // divider steps; the data edge is always step zero whatever the phase
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_reg <= sofc_pkg::STEP_FIRST;
        end else if (step_reg == sofc_pkg::STEP_LAST) begin
            step_reg <= sofc_pkg::STEP_FIRST;
        end else begin
            step_reg <= step_reg + 3'h1;
        end
    end

    always_comb begin
        phase_eff = act_phase_reg[sofc_pkg::PHASE_HI:0];
        if (phase_eff > sofc_pkg::PHASE_LAST) begin
            phase_eff = sofc_pkg::PHASE_LAST; // [R02]
        end
        // whole turns look the same on a periodic clock, so only the remainder matters
        tap_shift = phase_eff; // [R01]
        if (tap_shift >= sofc_pkg::TAP_COUNT) begin
            tap_shift = tap_shift - sofc_pkg::TAP_COUNT;
        end
        tap_idx = {1'b0, step_reg} + sofc_pkg::TAP_COUNT - tap_shift;
        if (tap_idx >= sofc_pkg::TAP_COUNT) begin
            tap_idx = tap_idx - sofc_pkg::TAP_COUNT;
        end
        dclk_next = tap_idx < sofc_pkg::TAP_HALF; // [R04]
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_output_data_clock <= 1'b0;
            o_frame_strobe      <= 1'b0;
        end else begin
            o_output_data_clock <= dclk_next; // [R01]
            o_frame_strobe      <= step_reg == sofc_pkg::STEP_FIRST; // [R11]
        end
    end

    always_comb begin
        cfg           = '0;
        cfg.fmt       = act_format_reg[sofc_pkg::FMT_HI:sofc_pkg::FMT_LO]; // [R05]
        cfg.invert    = act_format_reg[sofc_pkg::INV_BIT]; // [R05]
        cfg.test_mode = act_test_reg[sofc_pkg::TEST_HI:0]; // [R09]
        cfg.pat_one   = {act_p1h_reg, act_p1l_reg}; // [R06]
        cfg.pat_two   = {act_p2h_reg, act_p2l_reg}; // [R07] [R08]
    end

    assign o_drive_term = act_drive_reg[sofc_pkg::TERM_HI:sofc_pkg::TERM_LO];
    assign o_low_power  = act_format_reg[sofc_pkg::LOWPWR_BIT];

    sofc_formatter u_formatter (
        .i_clk        (i_clk),
        .i_rst_n      (rst_n),
        .i_cfg        (cfg),
        .i_sample     (i_sample),
        .i_load       (step_reg == sofc_pkg::STEP_FIRST),
        .o_word       (o_word),
        .o_word_valid (o_word_valid)
    );

endmodule : sofc_top

// ===== verilog/sofc_pkg.sv
// package for the serial output format configuration block
// register addresses, reset values, field positions, carriers and timing steps
package sofc_pkg;

    localparam int ADDR_W   = 13;
    localparam int SAMPLE_W = 12;
    localparam int PAT_W    = 16;

    localparam logic [12:0] ADDR_MODES   = 13'h0008;
    localparam logic [12:0] ADDR_TEST_IO = 13'h000d;
    localparam logic [12:0] ADDR_FORMAT  = 13'h0014;
    localparam logic [12:0] ADDR_DRIVE   = 13'h0015;
    localparam logic [12:0] ADDR_PHASE   = 13'h0016;
    localparam logic [12:0] ADDR_PAT1_LO = 13'h0019;
    localparam logic [12:0] ADDR_PAT1_HI = 13'h001a;
    localparam logic [12:0] ADDR_PAT2_LO = 13'h001b;
    localparam logic [12:0] ADDR_PAT2_HI = 13'h001c;
    localparam logic [12:0] ADDR_UPDATE  = 13'h00ff;

    localparam logic [7:0] RST_MODES   = 8'h00;
    localparam logic [7:0] RST_TEST_IO = 8'h00;
    localparam logic [7:0] RST_FORMAT  = 8'h00;
    localparam logic [7:0] RST_DRIVE   = 8'h00;
    localparam logic [7:0] RST_PHASE   = 8'h03;
    localparam logic [7:0] RST_PAT     = 8'h00;
    localparam logic [7:0] READ_NONE   = 8'h00;

    // field positions
    localparam int FMT_LO     = 0;
    localparam int FMT_HI     = 1;
    localparam int INV_BIT    = 2;
    localparam int LOWPWR_BIT = 6;
    localparam int TERM_LO    = 4;
    localparam int TERM_HI    = 5;
    localparam int PHASE_HI   = 3;
    localparam int TEST_HI    = 3;
    localparam int MODES_HI   = 2;
    localparam int XFER_BIT   = 0;
    localparam int READ_BIT   = 15;

    localparam logic [1:0] FMT_OFFSET  = 2'h0;
    localparam logic [1:0] FMT_TWOS    = 2'h1;
    localparam logic [3:0] TEST_USER   = 4'h8;
    localparam logic [2:0] MODES_RESET = 3'h3;

    // output data clock: six divider taps of 60 degrees per output clock period
    localparam logic [3:0] PHASE_LAST = 4'hb;
    localparam logic [3:0] TAP_COUNT  = 4'h6;
    localparam logic [3:0] TAP_HALF   = 4'h3;
    localparam logic [2:0] STEP_FIRST = 3'h0;
    localparam logic [2:0] STEP_LAST  = 3'h5;

    // serial port framing
    localparam logic [4:0] INSTR_LAST = 5'h0f;
    localparam logic [2:0] DATA_LAST  = 3'h7;

    typedef enum {
        SOFC_SPI_IDLE,
        SOFC_SPI_INSTR,
        SOFC_SPI_DATA
    } sofc_spi_state_t;

    typedef struct packed {
        logic [1:0]       fmt;
        logic             invert;
        logic [3:0]       test_mode;
        logic [PAT_W-1:0] pat_one;
        logic [PAT_W-1:0] pat_two;
    } sofc_cfg_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] data;
        logic                valid;
    } sofc_sample_t;

endpackage : sofc_pkg

// ===== verilog/sofc_formatter.sv
// output word formatter: format conversion, test pattern substitution, inversion
// assumes i_rst_n is already synchronised and i_load marks the data edge
`timescale 1ns/1ns
module sofc_formatter (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_n,
    input  sofc_pkg::sofc_cfg_t              i_cfg,
    input  sofc_pkg::sofc_sample_t           i_sample,
    input  wire logic                        i_load,
    output logic [sofc_pkg::SAMPLE_W-1:0]    o_word,
    output logic                             o_word_valid
);
    logic [sofc_pkg::SAMPLE_W-1:0] held_reg;
    logic                          pick_two_reg;
    logic [sofc_pkg::SAMPLE_W-1:0] conv;
    logic [sofc_pkg::SAMPLE_W-1:0] word_next;

    // capture follows the sample strobe only, never the phase tap [R04]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            held_reg <= '0;
        end else if (i_sample.valid) begin
            held_reg <= i_sample.data;
        end
    end

    // user mode alternates pattern one and pattern two, word by word
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pick_two_reg <= 1'b0;
        end else if (i_load && i_cfg.test_mode == sofc_pkg::TEST_USER) begin
            pick_two_reg <= !pick_two_reg;
        end else if (i_cfg.test_mode != sofc_pkg::TEST_USER) begin
            pick_two_reg <= 1'b0;
        end
    end

    always_comb begin
        conv = held_reg;
        if (i_cfg.fmt == sofc_pkg::FMT_TWOS) begin // [R05]
            conv[sofc_pkg::SAMPLE_W-1] = !held_reg[sofc_pkg::SAMPLE_W-1];
        end
        word_next = conv;
        if (i_cfg.test_mode == sofc_pkg::TEST_USER) begin // [R09]
            word_next = pick_two_reg ? i_cfg.pat_two[sofc_pkg::PAT_W-1 -: sofc_pkg::SAMPLE_W]
                                     : i_cfg.pat_one[sofc_pkg::PAT_W-1 -: sofc_pkg::SAMPLE_W];
        end
        if (i_cfg.invert) begin
            word_next = ~word_next; // [R05] [R11]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_word       <= '0;
            o_word_valid <= 1'b0;
        end else begin
            o_word_valid <= i_load;
            if (i_load) begin
                o_word <= word_next;
            end
        end
    end

endmodule : sofc_formatter

// ===== dv/sofc_top_sva.sv
// assertion checker for the serial output format block
// sees only top-level ports; bound to sofc_top from the testbench top
`timescale 1ns/1ns
module sofc_top_sva (
    input wire logic                         i_clk,
    input wire logic                         i_rst_n,
    input wire logic                         i_csb,
    input wire logic                         o_sdio_oe,
    input wire logic                         o_output_data_clock,
    input wire logic                         o_frame_strobe,
    input wire logic [sofc_pkg::SAMPLE_W-1:0] o_word,
    input wire logic                         o_word_valid,
    input wire logic [1:0]                   o_drive_term
);
    default clocking dcb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // phase moves only during a serial transfer, so the wave is judged with select high
    a_clock_high_three: assert property (disable iff (!i_rst_n || !i_csb)
        $rose(o_output_data_clock) |-> o_output_data_clock[*3] ##1 !o_output_data_clock)
        else $error("data clock high time wrong");
    a_clock_low_three: assert property (disable iff (!i_rst_n || !i_csb)
        $fell(o_output_data_clock) |-> !o_output_data_clock[*3] ##1 o_output_data_clock)
        else $error("data clock low time wrong");
    a_frame_period_six: assert property (o_frame_strobe |-> ##6 o_frame_strobe)
        else $error("frame strobe period wrong");
    a_valid_with_frame: assert property (o_word_valid == o_frame_strobe)
        else $error("word valid not with frame strobe");
    a_valid_gap_five: assert property (o_word_valid |=> !o_word_valid[*5])
        else $error("word valid too often");
    a_word_holds_steady: assert property (!o_word_valid |-> $stable(o_word))
        else $error("word changed without valid");
    a_oe_only_selected: assert property (o_sdio_oe |-> !i_csb)
        else $error("data pin driven while deselected");
    a_oe_not_early: assert property ($fell(i_csb) |-> !o_sdio_oe[*8])
        else $error("data pin driven before instruction");
    a_drive_by_xfer: assert property ($changed(o_drive_term) && $past(i_rst_n) |-> !i_csb)
        else $error("drive setting changed outside transfer");

    c_read_phase: cover property (o_sdio_oe);
    c_clock_at_frame: cover property (o_frame_strobe && o_output_data_clock);
    c_drive_update: cover property ($changed(o_drive_term));
endmodule : sofc_top_sva

// ===== dv/sofc_spi_host.sv
// serial port host model: one 24-bit frame per call, instruction then one byte
// assumes the read level is resolved outside and fed back on i_sdo
`timescale 1ns/1ns
module sofc_spi_host (
    input  wire logic i_clk,
    input  wire logic i_sdo,
    output logic      o_sclk,
    output logic      o_csb,
    output logic      o_sdi
);
    initial begin
        o_sclk = 1'b0;
        o_csb  = 1'b1;
        o_sdi  = 1'b0;
    end

    // four clocks per level keeps well above the one-clock sampling minimum
    task automatic xfer(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] fr;
        fr = {ins, wd};
        rd = 8'h00;
        @(posedge i_clk);
        o_csb <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            // line not owned by the host during read data: keep it moving
            o_sdi <= (i < 8 && ins[15]) ? ~o_sdi : fr[i];
            repeat (4) @(posedge i_clk);
            // take the bit at the rise: the device reloads on the last rise
            rd[i % 8] = (i < 8) ? i_sdo : rd[i % 8];
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        o_csb <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask : xfer
endmodule : sofc_spi_host

// ===== dv/serial_output_format_config_tb_top.sv
// testbench top for the serial output format block
// drives registers through the host model, checks data clock wave and output words
`timescale 1ns/1ns
`define CHK(nm, got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH %s exp=%h got=%h", nm, exp, got); end end
module serial_output_format_config_tb_top;
    logic                   clk;
    logic                   rst_n;
    sofc_pkg::sofc_sample_t sample;
    logic                   sclk, csb, host_sdi, dut_sdo, dut_oe, odc, frame, wvalid, low_pwr;
    logic [11:0]            word, w0, w1;
    logic [1:0]             drive;
    logic [7:0]             rd_v, f;
    logic [5:0]             wave;
    wire logic              sdio_w;
    int                     n_mismatch = 0;
    int                     n_checks = 0;
    localparam logic [11:0] SMP  = 12'h5a3;
    localparam logic [31:0] PATS = 32'h1e7fc3a5;

    assign sdio_w = dut_oe ? dut_sdo : host_sdi;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    sofc_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_csb(csb), .i_sdio(sdio_w),
        .o_sdio(dut_sdo), .o_sdio_oe(dut_oe), .i_sample(sample), .o_output_data_clock(odc),
        .o_frame_strobe(frame), .o_word(word), .o_word_valid(wvalid), .o_drive_term(drive),
        .o_low_power(low_pwr));
    sofc_spi_host u_host (.i_clk(clk), .i_sdo(sdio_w), .o_sclk(sclk), .o_csb(csb),
        .o_sdi(host_sdi));

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] tmp;
        u_host.xfer({3'h0, a}, d, tmp);
    endtask : wr
    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        u_host.xfer({3'h4, a}, 8'h00, d);
    endtask : rd
    task automatic commit();
        wr(sofc_pkg::ADDR_UPDATE, 8'h01);
    endtask : commit
    task automatic get_word(output logic [11:0] w);
        int k;
        k = 0;
        @(negedge clk);
        while (wvalid !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        `CHK("word_valid", wvalid, 1'b1)
        w = word;
    endtask : get_word
    task automatic get_wave(output logic [5:0] v);
        int k;
        k = 0;
        @(negedge clk);
        while (frame !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        `CHK("frame_strobe", frame, 1'b1)
        for (int i = 0; i < 6; i++) begin
            v[i] = odc;
            @(negedge clk);
        end
    endtask : get_wave
    function automatic logic [5:0] exp_wave(input logic [3:0] code);
        int         s;
        logic [5:0] v;
        s = ((code > 4'hb) ? 11 : int'(code)) % 6;
        for (int k = 0; k < 6; k++)
            v[k] = ((k - s + 6) % 6) < 3;
        return v;
    endfunction : exp_wave
    function automatic logic [11:0] exp_word(input logic [7:0] fm, input logic [11:0] d);
        logic [11:0] r;
        r = fm[0] ? {~d[11], d[10:0]} : d;
        return fm[2] ? ~r : r;
    endfunction : exp_word
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // sized from 67 frames of roughly 201 clocks each, with margin
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        sample = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        sample <= '{data: SMP, valid: 1'b1};
        repeat (8) @(posedge clk);
        for (int a = 20; a <= 28; a++) begin
            rd(13'(a), rd_v);
            `CHK("reset_value", rd_v, (a == 22) ? sofc_pkg::RST_PHASE : 8'h00)
        end
        get_wave(wave);
        `CHK("clock_wave", wave, exp_wave(4'h3))
        wr(sofc_pkg::ADDR_PHASE, 8'h00);
        get_wave(wave);
        `CHK("clock_wave_staged", wave, exp_wave(4'h3))
        for (int c = 0; c < 16; c++) begin
            wr(sofc_pkg::ADDR_PHASE, 8'(c));
            commit();
            get_wave(wave);
            `CHK("clock_wave", wave, exp_wave(4'(c)))
        end
        for (int i = 0; i < 4; i++) begin
            f = {5'h00, i[1], 1'b0, i[0]};
            wr(sofc_pkg::ADDR_FORMAT, f);
            commit();
            get_word(w0);
            get_word(w0);
            `CHK("format_word", w0, exp_word(f, SMP))
        end
        for (int i = 0; i < 4; i++)
            wr(sofc_pkg::ADDR_PAT1_LO + 13'(i), PATS[8*i +: 8]);
        for (int i = 0; i < 4; i++) begin
            rd(sofc_pkg::ADDR_PAT1_LO + 13'(i), rd_v);
            `CHK("pattern_byte", rd_v, PATS[8*i +: 8])
        end
        wr(sofc_pkg::ADDR_FORMAT, 8'h40);
        wr(sofc_pkg::ADDR_DRIVE, 8'h20);
        wr(sofc_pkg::ADDR_TEST_IO, 8'h08);
        commit();
        get_word(w0);
        get_word(w1);
        `CHK("user_pair", ({w0, w1} === 24'hc3a1e7 || {w0, w1} === 24'h1e7c3a), 1'b1)
        `CHK("drive_term", drive, 2'h2)
        `CHK("low_power", low_pwr, 1'b1)
        wr(sofc_pkg::ADDR_MODES, 8'h03);
        commit();
        rd(sofc_pkg::ADDR_PHASE, rd_v);
        `CHK("soft_reset", {rd_v, drive, low_pwr}, 11'h018)
        wr(13'h0030, 8'h5a);
        rd(13'h0030, rd_v);
        `CHK("unmapped_read", rd_v, 8'h00)
        wrap_up();
    end
endmodule : serial_output_format_config_tb_top

bind sofc_top sofc_top_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_csb(i_csb),
    .o_sdio_oe(o_sdio_oe), .o_output_data_clock(o_output_data_clock),
    .o_frame_strobe(o_frame_strobe), .o_word(o_word), .o_word_valid(o_word_valid),
    .o_drive_term(o_drive_term));
